/* design/rbm_pkg.sv */
// Shared constants and types for the receive buffer ring manager
package rbm_pkg;

	// Register byte offsets on the APB
	localparam logic [7:0] RBM_OFF_COMMAND = 8'h00;
	localparam logic [7:0] RBM_OFF_PAGE_START = 8'h04;
	localparam logic [7:0] RBM_OFF_PAGE_STOP = 8'h08;
	localparam logic [7:0] RBM_OFF_BOUNDARY = 8'h0c;
	localparam logic [7:0] RBM_OFF_CURRENT = 8'h10;
	localparam logic [7:0] RBM_OFF_INT_STATUS = 8'h14;
	localparam logic [7:0] RBM_OFF_RX_CONFIG = 8'h18;
	localparam logic [7:0] RBM_OFF_TX_CONFIG = 8'h1c;
	localparam logic [7:0] RBM_OFF_REMOTE_LOW = 8'h20;
	localparam logic [7:0] RBM_OFF_REMOTE_HIGH = 8'h24;
	localparam logic [7:0] RBM_OFF_MISSED = 8'h28;
	localparam logic [7:0] RBM_OFF_UPPER_ADDR = 8'h2c;
	localparam logic [7:0] RBM_OFF_DMA_ADDR = 8'h30;

	// Command register fields
	localparam int RBM_CMD_STOP = 0;
	localparam int RBM_CMD_START = 1;
	localparam int RBM_CMD_TXP = 2;
	localparam logic [7:0] RBM_CMD_RESET = 8'h21;

	// Interrupt status fields
	localparam int RBM_IS_RX_OK = 0;
	localparam int RBM_IS_TX_SENT = 1;
	localparam int RBM_IS_RX_ERR = 2;
	localparam int RBM_IS_TX_ERR = 3;
	localparam int RBM_IS_OVERWRITE = 4;
	localparam int RBM_IS_RESET = 7;

	// Configuration fields
	localparam int RBM_RXC_ACCEPT_ERR = 0;
	localparam int RBM_TXC_LOOP_LO = 1;
	localparam int RBM_TXC_LOOP_HI = 2;

	// Page layout and header size
	localparam logic [7:0] RBM_HDR_BYTES = 8'h04;
	localparam logic [7:0] RBM_PAGE_LAST = 8'hff;

	// Frame check sequence constants, reflected form
	localparam logic [31:0] RBM_CRC_POLY = 32'hedb88320;
	localparam logic [31:0] RBM_CRC_INIT = 32'hffffffff;
	localparam logic [31:0] RBM_CRC_RESIDUE = 32'hdebb20e3;

	typedef enum {RX_IDLE, RX_STORE, RX_DROP, RX_HEADER} rbm_rx_state_type;
	typedef enum {TX_IDLE, TX_DATA, TX_FCS} rbm_tx_state_type;

endpackage : rbm_pkg

/* design/rbm_if.sv */
// Carriers between the ring manager core and its helper modules
`timescale 1ns/1ps

interface rbm_crc_if;
	logic clear;
	logic feed;
	logic [7:0] data;
	logic [31:0] value;
	logic residue_ok;
	modport user (output clear, output feed, output data,
		input value, input residue_ok);
	modport engine (input clear, input feed, input data,
		output value, output residue_ok);
endinterface : rbm_crc_if

interface rbm_link_if;
	logic [7:0] page;
	logic [7:0] start;
	logic [7:0] stop;
	logic [7:0] boundary;
	logic [7:0] next_page;
	logic hit_boundary;
	modport user (output page, output start, output stop, output boundary,
		input next_page, input hit_boundary);
	modport engine (input page, input start, input stop, input boundary,
		output next_page, output hit_boundary);
endinterface : rbm_link_if

/* design/rbm_crc.sv */
// Byte-wide 32-bit frame check sequence engine
`timescale 1ns/1ps

module rbm_crc
	import rbm_pkg::*;
(
	input wire logic pclk, // Bus clock
	input wire logic presetn, // Async reset, active low
	rbm_crc_if.engine crc // Feed and result
);

	typedef struct packed {
		logic [31:0] crc;
	} rbm_crc_state_type;

	rbm_crc_state_type st;
	rbm_crc_state_type next_st;

	// One byte through the reflected polynomial, low bit first
	function automatic logic [31:0] rbm_crc_byte(input logic [31:0] c,
		input logic [7:0] d);
		logic [31:0] r;
		r = c ^ {24'h000000, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ RBM_CRC_POLY) : (r >> 1); // R9
		end
		return r;
	endfunction : rbm_crc_byte

	// Clear and feed may coincide on the first byte of a frame
	always_comb begin
		logic [31:0] base;
		base = crc.clear ? RBM_CRC_INIT : st.crc;
		next_st.crc = crc.feed ? rbm_crc_byte(base, crc.data) : base;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '{crc: RBM_CRC_INIT};
		end else begin
			st <= next_st;
		end
	end

	// A good frame, its own sequence included, leaves a fixed residue
	assign crc.value = st.crc;
	assign crc.residue_ok = (st.crc == RBM_CRC_RESIDUE); // R9

endmodule : rbm_crc

/* design/rbm_link.sv */
// Next-page computation with ring wrap and boundary test
`timescale 1ns/1ps

module rbm_link
	import rbm_pkg::*;
(
	rbm_link_if.engine lnk // Page in, next page and hit out
);

	logic [7:0] inc_page;

	// Pages are whole upper address bytes, so one value is one page
	assign inc_page = lnk.page + 8'h01; // R25 R7
	// Stop compare first, then boundary on the wrapped value
	assign lnk.next_page = (inc_page == lnk.stop) ? lnk.start : inc_page; // R2 R8
	assign lnk.hit_boundary = (lnk.next_page == lnk.boundary); // R8 R5

endmodule : rbm_link

/* design/rbm_ring.sv */
// Receive buffer ring manager: APB registers, receive DMA and transmit FCS
`timescale 1ns/1ps

// Overview of operation
// R1 - Packets land in a ring of contiguous 256-byte pages
// R2 - DMA page reaching page stop reloads with page start
// R3 - Software never programs page start as zero
// R4 - Current page locates the header and rewinds after rejected packets
// R5 - Reaching the boundary page aborts reception, keeping unread packets
// R6 - Packet starts at current page, skipping four header bytes
// R7 - Full page continues in the very next page, no skipping
// R8 - Next page: test stop and wrap, then test boundary and abort
// R9 - 32-bit FCS appended on transmit and checked on receive
// R10 - Upper 16 address bits stay static, selecting a 64 kbyte window
// R11 - Every overflow needs full stop and restart recovery by software
// R12 - Recovery saves transmit pending then writes 0x21 to stop
// R13 - Stop lets the frame in progress finish before idling
// R14 - Software waits 1.6 ms, not trusting the reset status flag
// R15 - Recovery clears both remote byte count registers
// R16 - Resend only if pending and neither sent nor error flagged
// R17 - Software enters loopback 1 or 2 through config bits 2,1
// R18 - Software writes 0x22 to start, enabling packet draining
// R19 - After draining, software clears the overwrite warning flag
// R20 - Software leaves loopback with config bits 2,1 both zero
// R21 - With resend set, software clears it and writes 0x26
// R22 - Missed-packet tally holds still while stopped
// R23 - Accepted packet: header at first page, then current page advances
// R24 - Rejected packet rewinds to current page unless errors are accepted
// R25 - Page compares use the upper byte of the local address
module rbm_ring
	import rbm_pkg::*;
(
	input wire logic pclk, // Bus and DMA clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready, never waits
	output logic pslverr, // APB error on unmapped address
	input wire logic rx_valid, // Receive byte present
	input wire logic [7:0] rx_data, // Receive byte
	input wire logic rx_end, // Frame ended, pulse without data
	input wire logic rx_runt, // Frame was a runt, valid with rx_end
	input wire logic rx_align, // Alignment error, valid with rx_end
	input wire logic tx_in_valid, // Transmit byte offered
	input wire logic [7:0] tx_in_data, // Transmit byte
	input wire logic tx_in_last, // Last byte before the FCS
	output logic tx_in_ready, // Transmit byte taken
	output logic tx_out_valid, // Byte to the wire
	output logic [7:0] tx_out_data, // Byte to the wire
	input wire logic tx_fail, // Transmit failure pin, asynchronous
	output logic mem_we, // Buffer memory write strobe
	output logic [31:0] mem_addr, // Buffer memory byte address
	output logic [7:0] mem_wdata, // Buffer memory write data
	output logic stopped // Stopped and idle
);

	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] page_start_reg;
		logic [7:0] page_stop_reg;
		logic [7:0] boundary_reg;
		logic [7:0] current_page_reg;
		logic [7:0] interrupt_status_reg;
		logic [7:0] rx_cfg;
		logic [7:0] tx_cfg;
		logic [7:0] remote_count_low;
		logic [7:0] remote_count_high;
		logic [7:0] missed;
		logic [15:0] upper;
		logic [31:0] rdata;
		logic slverr;
		rbm_rx_state_type rxs;
		logic [15:0] waddr;
		logic [15:0] count;
		logic [7:0] next_free;
		logic [1:0] hdr_idx;
		logic [7:0] status_byte;
		logic we;
		logic [15:0] maddr;
		logic [7:0] wdata;
		rbm_tx_state_type txs;
		logic [1:0] fcs_idx;
		logic out_valid;
		logic [7:0] out_data;
		logic fail_s1;
		logic fail_s2;
		logic fail_s3;
	} rbm_state_type;

	rbm_state_type st;
	rbm_state_type next_st;

	rbm_crc_if rxc ();
	rbm_crc_if txc ();
	rbm_link_if lnk ();

	logic running;
	logic loopback;
	logic start_rx;
	logic fail_rise;

	// Address decode shared by read and write paths
	function automatic logic rbm_mapped(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= RBM_OFF_DMA_ADDR);
	endfunction : rbm_mapped

	function automatic logic [31:0] rbm_read(input rbm_state_type s,
		input logic [7:0] a);
		case (a)
			RBM_OFF_COMMAND: return {24'h000000, s.cmd};
			RBM_OFF_PAGE_START: return {24'h000000, s.page_start_reg};
			RBM_OFF_PAGE_STOP: return {24'h000000, s.page_stop_reg};
			RBM_OFF_BOUNDARY: return {24'h000000, s.boundary_reg};
			RBM_OFF_CURRENT: return {24'h000000, s.current_page_reg};
			RBM_OFF_INT_STATUS: return {24'h000000, s.interrupt_status_reg};
			RBM_OFF_RX_CONFIG: return {24'h000000, s.rx_cfg};
			RBM_OFF_TX_CONFIG: return {24'h000000, s.tx_cfg};
			RBM_OFF_REMOTE_LOW: return {24'h000000, s.remote_count_low};
			RBM_OFF_REMOTE_HIGH: return {24'h000000, s.remote_count_high};
			RBM_OFF_MISSED: return {24'h000000, s.missed};
			RBM_OFF_UPPER_ADDR: return {16'h0000, s.upper};
			RBM_OFF_DMA_ADDR: return {16'h0000, s.waddr};
			default: return 32'h00000000;
		endcase
	endfunction : rbm_read

	rbm_crc u_rx_crc (
		.pclk(pclk),
		.presetn(presetn),
		.crc(rxc.engine)
	);

	rbm_crc u_tx_crc (
		.pclk(pclk),
		.presetn(presetn),
		.crc(txc.engine)
	);

	rbm_link u_link (
		.lnk(lnk.engine)
	);

	assign running = !st.cmd[RBM_CMD_STOP];
	// Loopback keeps the local receive DMA off
	assign loopback = st.tx_cfg[RBM_TXC_LOOP_HI] | st.tx_cfg[RBM_TXC_LOOP_LO];
	assign start_rx = (st.rxs == RX_IDLE) && rx_valid && running && !loopback;
	// Edge detect reads only the settled stages of the synchroniser
	assign fail_rise = st.fail_s2 & ~st.fail_s3;

	// Link helper looks at the page of the byte being stored
	assign lnk.page = (st.rxs == RX_STORE) ? st.waddr[15:8] : st.current_page_reg;
	assign lnk.start = st.page_start_reg;
	assign lnk.stop = st.page_stop_reg;
	assign lnk.boundary = st.boundary_reg;

	assign rxc.clear = start_rx;
	assign rxc.feed = rx_valid && (start_rx || (st.rxs == RX_STORE)); // R9
	assign rxc.data = rx_data;
	assign txc.clear = (st.txs == TX_IDLE);
	assign txc.feed = (st.txs == TX_DATA) && tx_in_valid; // R9
	assign txc.data = tx_in_data;

	always_comb begin
		logic bad;
		logic crc_bad;
		next_st = st;
		next_st.we = 1'b0;
		next_st.out_valid = 1'b0;
		next_st.fail_s1 = tx_fail;
		next_st.fail_s2 = st.fail_s1;
		next_st.fail_s3 = st.fail_s2;
		crc_bad = !rxc.residue_ok;
		bad = (crc_bad || rx_runt || rx_align) && !st.rx_cfg[RBM_RXC_ACCEPT_ERR];

		// Read data and error are caught in the setup cycle
		if (psel && !penable) begin
			next_st.rdata = rbm_read(st, paddr);
			next_st.slverr = !rbm_mapped(paddr);
		end

		// Writes take effect in the access cycle
		if (psel && penable && pwrite) begin
			case (paddr)
				RBM_OFF_COMMAND: begin
					next_st.cmd = pwdata[7:0];
					// A pending transmit is only cancelled by the engine
					next_st.cmd[RBM_CMD_TXP] = st.cmd[RBM_CMD_TXP] | pwdata[RBM_CMD_TXP];
				end
				RBM_OFF_PAGE_START: next_st.page_start_reg = pwdata[7:0];
				RBM_OFF_PAGE_STOP: next_st.page_stop_reg = pwdata[7:0];
				RBM_OFF_BOUNDARY: next_st.boundary_reg = pwdata[7:0];
				RBM_OFF_CURRENT: next_st.current_page_reg = pwdata[7:0];
				RBM_OFF_INT_STATUS: begin
					next_st.interrupt_status_reg = st.interrupt_status_reg & ~pwdata[7:0];
				end
				RBM_OFF_RX_CONFIG: next_st.rx_cfg = pwdata[7:0];
				RBM_OFF_TX_CONFIG: next_st.tx_cfg = pwdata[7:0];
				RBM_OFF_REMOTE_LOW: next_st.remote_count_low = pwdata[7:0];
				RBM_OFF_REMOTE_HIGH: next_st.remote_count_high = pwdata[7:0];
				RBM_OFF_UPPER_ADDR: next_st.upper = pwdata[15:0];
				default: ;
			endcase
		end

		// Receive DMA; flag sets below override a same-cycle clear
		case (st.rxs)
			RX_IDLE: begin
				if (start_rx) begin
					next_st.we = 1'b1;
					next_st.maddr = {st.current_page_reg, RBM_HDR_BYTES}; // R6 R1
					next_st.wdata = rx_data;
					next_st.waddr = {st.current_page_reg, RBM_HDR_BYTES} + 16'h0001;
					next_st.count = {8'h00, RBM_HDR_BYTES} + 16'h0001;
					next_st.rxs = RX_STORE;
				end else if (rx_valid) begin
					// Stopped or in loopback: let the frame pass unstored
					next_st.rxs = RX_DROP;
				end
			end
			RX_STORE: begin
				if (rx_end) begin
					if (bad) begin
						// Current page untouched, so every page used is reclaimed
						next_st.waddr = {st.current_page_reg, RBM_HDR_BYTES}; // R24 R4
						next_st.interrupt_status_reg[RBM_IS_RX_ERR] = 1'b1;
						next_st.rxs = RX_IDLE;
					end else begin
						// Leftover bytes of the last page are given up
						next_st.next_free = (st.waddr[7:0] == 8'h00) ?
							st.waddr[15:8] : lnk.next_page; // R23
						next_st.status_byte = {5'h00, rx_align, crc_bad, 1'b1};
						next_st.hdr_idx = 2'b00;
						next_st.rxs = RX_HEADER;
					end
				end else if (rx_valid) begin
					next_st.we = 1'b1;
					next_st.maddr = st.waddr;
					next_st.wdata = rx_data;
					next_st.waddr = st.waddr + 16'h0001;
					next_st.count = st.count + 16'h0001;
					if (st.waddr[7:0] == RBM_PAGE_LAST) begin
						if (lnk.hit_boundary) begin
							// Unread pages stay intact; the rest of the frame is lost
							next_st.interrupt_status_reg[RBM_IS_OVERWRITE] = 1'b1; // R5 R8
							if (running && (st.missed != 8'hff)) begin
								next_st.missed = st.missed + 8'h01; // R22
							end
							next_st.rxs = RX_DROP;
						end else begin
							next_st.waddr = {lnk.next_page, 8'h00}; // R7 R8 R2
						end
					end
				end
			end
			RX_DROP: begin
				if (rx_end) begin
					next_st.rxs = RX_IDLE;
				end
			end
			RX_HEADER: begin
				// Header goes back to the packet's first page
				next_st.we = 1'b1;
				next_st.maddr = {st.current_page_reg, 6'h00, st.hdr_idx}; // R4 R23
				case (st.hdr_idx)
					2'b00: next_st.wdata = st.status_byte;
					2'b01: next_st.wdata = st.next_free;
					2'b10: next_st.wdata = st.count[7:0];
					default: next_st.wdata = st.count[15:8];
				endcase
				next_st.hdr_idx = st.hdr_idx + 2'b01;
				if (st.hdr_idx == 2'b11) begin
					next_st.current_page_reg = st.next_free; // R23
					next_st.interrupt_status_reg[RBM_IS_RX_OK] = 1'b1;
					next_st.rxs = RX_IDLE;
				end
			end
			default: next_st.rxs = RX_IDLE;
		endcase

		// Transmit path; a stop does not cut a frame already started
		case (st.txs)
			TX_IDLE: begin
				if (st.cmd[RBM_CMD_TXP] && running) begin
					next_st.txs = TX_DATA;
				end
			end
			TX_DATA: begin
				if (tx_in_valid) begin
					next_st.out_valid = 1'b1;
					next_st.out_data = tx_in_data;
					if (tx_in_last) begin
						next_st.fcs_idx = 2'b00;
						next_st.txs = TX_FCS;
					end
				end
			end
			TX_FCS: begin
				// Sequence goes out inverted, low byte first
				next_st.out_valid = 1'b1;
				next_st.out_data = ~txc.value[8 * st.fcs_idx +: 8]; // R9
				next_st.fcs_idx = st.fcs_idx + 2'b01;
				if (st.fcs_idx == 2'b11) begin
					next_st.cmd[RBM_CMD_TXP] = 1'b0;
					next_st.interrupt_status_reg[RBM_IS_TX_SENT] = 1'b1;
					next_st.txs = TX_IDLE;
				end
			end
			default: next_st.txs = TX_IDLE;
		endcase
		if (fail_rise && (st.txs != TX_IDLE)) begin
			next_st.cmd[RBM_CMD_TXP] = 1'b0;
			next_st.interrupt_status_reg[RBM_IS_TX_ERR] = 1'b1;
			next_st.txs = TX_IDLE;
		end

		// Idle only once both channels have let their frames finish
		if (!running && (st.rxs == RX_IDLE) && (st.txs == TX_IDLE)) begin
			next_st.interrupt_status_reg[RBM_IS_RESET] = 1'b1; // R13
		end else if (running) begin
			next_st.interrupt_status_reg[RBM_IS_RESET] = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.cmd <= RBM_CMD_RESET;
			st.rxs <= RX_IDLE;
			st.txs <= TX_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.rdata;
	assign pready = 1'b1;
	assign pslverr = st.slverr;
	assign tx_in_ready = (st.txs == TX_DATA);
	assign tx_out_valid = st.out_valid;
	assign tx_out_data = st.out_data;
	assign mem_we = st.we;
	assign mem_addr = {st.upper, st.maddr}; // R10
	assign mem_wdata = st.wdata;
	assign stopped = st.interrupt_status_reg[RBM_IS_RESET];

endmodule : rbm_ring

/* bench/rbm_ring_asserts.sv */
// Port-level assertions for the receive buffer ring manager
`timescale 1ns/1ps
module rbm_ring_asserts
	import rbm_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB address
	input wire logic [31:0] prdata, // APB read data
	input wire logic pslverr, // APB error
	input wire logic tx_in_valid, // Transmit offer
	input wire logic tx_in_ready, // Transmit take
	input wire logic tx_in_last, // Last payload byte
	input wire logic tx_out_valid, // Wire byte
	input wire logic mem_we, // Memory write
	input wire logic [31:0] mem_addr, // Memory address
	input wire logic stopped // Stopped and idle
);
	// Access phase and refused addresses
	wire acc = psel && penable;
	wire bad = paddr[1:0] != 2'b00 || paddr > 8'h30;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_unmapped_err:
		assert property (acc && bad |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	a_mapped_ok:
		assert property (acc && !bad |-> !pslverr)
		else $error("mapped access flagged");
	a_read_narrow:
		assert property (acc && !pwrite && paddr < 8'h2c |-> prdata[31:8] == 0)
		else $error("upper read bits set");
	a_fcs_hold:
		assert property (tx_in_valid && tx_in_ready && tx_in_last
			|=> (!tx_in_ready) [*4]) else $error("ready during check bytes");
	a_fcs_count:
		assert property (tx_in_valid && tx_in_ready && tx_in_last
			|=> tx_out_valid [*5]) else $error("check bytes missing");
	a_stopped_quiet:
		assert property (stopped |-> !mem_we && !tx_out_valid)
		else $error("activity while stopped");
	a_upper_static:
		assert property (mem_we ##1 mem_we |-> $stable(mem_addr[31:16]))
		else $error("upper address moved");
	a_header_run:
		assert property (mem_we && mem_addr[7:0] == 8'h00 |=> mem_we &&
			mem_addr[7:0] == 8'h01 ##1 mem_we && mem_addr[7:0] == 8'h02)
		else $error("page start writes not consecutive");
	cover property (mem_we && mem_addr[7:0] == 8'hff ##1 mem_we);
	cover property (tx_in_valid && tx_in_ready && tx_in_last);
	cover property (acc && pslverr);
endmodule : rbm_ring_asserts

/* bench/rbm_buffer_mem.sv */
// Buffer memory model on the local DMA bus
`timescale 1ns/1ps
module rbm_buffer_mem (
	input wire logic pclk, // Clock
	input wire logic mem_we, // Write strobe
	input wire logic [31:0] mem_addr, // Byte address
	input wire logic [7:0] mem_wdata // Byte to store
);
	logic [7:0] mem [int];
	logic [15:0] up;
	int wr_count = 0;
	// Write-only store; the ring never reads back, so no data lines return
	always @(posedge pclk) if (mem_we === 1'b1) begin
		mem[mem_addr[15:0]] = mem_wdata;
		up = mem_addr[31:16];
		wr_count++;
	end
endmodule : rbm_buffer_mem

/* bench/test_receive_buffer_ring_manager.sv */
// Self-checking bench for the receive buffer ring manager
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
	err_count++; $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module test_receive_buffer_ring_manager;
	import rbm_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
	logic rx_valid = 0, rx_end = 0, rx_runt = 0, rx_align = 0;
	logic tx_in_valid = 0, tx_in_last = 0, pready, pslverr, tx_in_ready;
	logic tx_fail = 0;
	logic tx_out_valid, mem_we, stopped;
	logic [7:0] paddr = 0, rx_data = 0, tx_in_data = 0, tx_out_data, mem_wdata;
	logic [31:0] pwdata = 0, rd, prdata, mem_addr;
	logic [7:0] q[$], txq[$];
	int err_count = 0, checks_done = 0, seed = 97453;
	int st = 1, sp = 4, bnd = 1, cur = 2;
	always #20 pclk = ~pclk;
	rbm_ring dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
		.rx_runt(rx_runt), .rx_align(rx_align), .tx_in_valid(tx_in_valid),
		.tx_in_data(tx_in_data), .tx_in_last(tx_in_last),
		.tx_in_ready(tx_in_ready), .tx_out_valid(tx_out_valid),
		.tx_out_data(tx_out_data), .tx_fail(tx_fail), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .stopped(stopped));
	rbm_buffer_mem bm_u (.pclk(pclk), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata));
	// Wire bytes, seen before the edge's own updates land
	always @(posedge pclk) if (tx_out_valid === 1'b1) txq.push_back(tx_out_data);
	// APB master: request held until the edge that samples pready high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : rchk
	// Random frame with a valid check sequence, low byte first
	task automatic mk(input int n);
		logic [31:0] c;
		q.delete();
		repeat (n - 4) q.push_back(8'($random(seed)));
		c = 32'hffffffff;
		foreach (q[i]) begin
			c = c ^ {24'h0, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
		end
		for (int i = 0; i < 4; i++) q.push_back(~c[8 * i +: 8]);
	endtask : mk
	// Back-to-back bytes, then the end pulse with its error levels
	task automatic send(input logic [1:0] e);
		foreach (q[i]) begin
			@(posedge pclk);
			rx_valid <= 1'b1;
			rx_data <= q[i];
		end
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_end <= 1'b1;
		{rx_align, rx_runt} <= e;
		@(posedge pclk);
		rx_end <= 1'b0;
		{rx_align, rx_runt} <= 2'b00;
		repeat (8) @(posedge pclk);
	endtask : send
	// Frame in flight with a stop command landing in its middle
	task automatic stop_mid;
		fork
			send(2'b00);
			begin
				repeat (30) @(posedge pclk);
				apb(1'b1, RBM_OFF_COMMAND, 32'h21);
			end
		join
	endtask : stop_mid
	// Reference ring walk: where each byte lands, links and aborts
	task automatic model(output int nx);
		int p;
		int o;
		bit ab;
		p = cur;
		o = 4;
		ab = 1'b0;
		foreach (q[i]) begin
			if (!ab) `CHK(bm_u.mem[p * 256 + o], q[i])
			if (o == 255 && !ab) begin
				p = (p + 1 == sp) ? st : p + 1;
				ab = p == bnd;
				o = 0;
			end else o++;
		end
		// A frame ending on a page edge has already linked its next page
		nx = (o == 0) ? p : ((p + 1 == sp) ? st : p + 1);
	endtask : model
	task automatic hdr(input int nx);
		`CHK(bm_u.mem[cur * 256], 8'h01)
		`CHK(bm_u.mem[cur * 256 + 1], nx[7:0])
		`CHK(bm_u.mem[cur * 256 + 2], 8'(q.size() + 4))
		`CHK(bm_u.mem[cur * 256 + 3], 8'((q.size() + 4) >> 8))
		rchk(RBM_OFF_CURRENT, nx);
		cur = nx;
	endtask : hdr
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done
	// Watchdog well beyond the expected run of some 42000 cycles
	initial begin
		#4000000;
		err_count++;
		test_done;
	end
	initial begin
		int nx;
		int wc;
		bit rs;
		logic [15:0] up;
		up = 16'($random(seed));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rchk(RBM_OFF_COMMAND, 32'h21);
		rchk(RBM_OFF_PAGE_START, 32'h0);
		apb(1'b0, 8'h02, 32'h0);
		`CHK(se, 1'b1)
		apb(1'b1, 8'h34, 32'hff);
		`CHK(se, 1'b1)
		$display("done: reset and map");
		apb(1'b1, RBM_OFF_UPPER_ADDR, {16'h0, up});
		apb(1'b1, RBM_OFF_PAGE_START, st);
		apb(1'b1, RBM_OFF_PAGE_STOP, sp);
		apb(1'b1, RBM_OFF_BOUNDARY, bnd);
		apb(1'b1, RBM_OFF_CURRENT, cur);
		apb(1'b1, RBM_OFF_COMMAND, 32'h22);
		// Spans two pages; the next packet wraps round to page start
		mk(300);
		send(2'b00);
		model(nx);
		hdr(nx);
		`CHK(bm_u.up, up)
		$display("done: accept and link");
		// Runt, alignment and check failures all give their pages back
		for (int k = 0; k < 3; k++) begin
			mk(64);
			if (k == 2) q[9] = ~q[9];
			wc = bm_u.wr_count;
			send(k == 2 ? 2'b00 : 2'(k + 1));
			model(nx);
			`CHK(bm_u.wr_count - wc, 64)
			rchk(RBM_OFF_CURRENT, cur);
			apb(1'b0, RBM_OFF_INT_STATUS, 32'h0);
			`CHK(rd[RBM_IS_RX_ERR], 1'b1)
			apb(1'b1, RBM_OFF_INT_STATUS, 32'h04);
		end
		$display("done: rejects");
		// Boundary one page ahead: writing stops at the crossing
		bnd = 2;
		apb(1'b1, RBM_OFF_BOUNDARY, bnd);
		mk(300);
		wc = bm_u.wr_count;
		send(2'b00);
		model(nx);
		`CHK(bm_u.wr_count - wc, 252)
		rchk(RBM_OFF_CURRENT, cur);
		rchk(RBM_OFF_MISSED, 32'h1);
		apb(1'b0, RBM_OFF_INT_STATUS, 32'h0);
		`CHK(rd[RBM_IS_OVERWRITE], 1'b1)
		$display("done: boundary abort");
		// Stop lands before the boundary crossing: no tally while stopped
		mk(300);
		wc = bm_u.wr_count;
		stop_mid;
		`CHK(bm_u.wr_count - wc, 252)
		rchk(RBM_OFF_MISSED, 32'h1);
		`CHK(stopped, 1'b1)
		apb(1'b1, RBM_OFF_COMMAND, 32'h22);
		$display("done: stopped abort");
		// Overflow recovery, with the stop landing in mid-packet
		bnd = 3;
		apb(1'b1, RBM_OFF_BOUNDARY, bnd);
		apb(1'b0, RBM_OFF_COMMAND, 32'h0);
		rs = rd[RBM_CMD_TXP];
		mk(100);
		stop_mid;
		model(nx);
		hdr(nx);
		for (int i = 0; i < 100 && stopped !== 1'b1; i++) @(posedge pclk);
		`CHK(stopped, 1'b1)
		repeat (40000) @(posedge pclk);
		apb(1'b1, RBM_OFF_REMOTE_LOW, 32'h0);
		apb(1'b1, RBM_OFF_REMOTE_HIGH, 32'h0);
		wc = bm_u.wr_count;
		send(2'b00);
		rchk(RBM_OFF_MISSED, 32'h1);
		apb(1'b0, RBM_OFF_INT_STATUS, 32'h0);
		rs = rs && !rd[RBM_IS_TX_SENT] && !rd[RBM_IS_TX_ERR];
		for (int lb = 2; lb <= 4; lb += 2) begin
			apb(1'b1, RBM_OFF_TX_CONFIG, lb);
			apb(1'b1, RBM_OFF_COMMAND, 32'h22);
			send(2'b00);
		end
		`CHK(bm_u.wr_count - wc, 0)
		apb(1'b1, RBM_OFF_INT_STATUS, 32'h10);
		apb(1'b0, RBM_OFF_INT_STATUS, 32'h0);
		`CHK(rd[RBM_IS_OVERWRITE], 1'b0)
		apb(1'b1, RBM_OFF_TX_CONFIG, 32'h0);
		if (rs) apb(1'b1, RBM_OFF_COMMAND, 32'h26);
		$display("done: recovery");
		// Failure pin rise mid-frame ends it and drops the pending bit
		apb(1'b1, RBM_OFF_COMMAND, 32'h26);
		tx_in_valid <= 1'b1;
		repeat (6) @(posedge pclk);
		tx_fail <= 1'b1;
		repeat (6) @(posedge pclk);
		tx_in_valid <= 1'b0;
		tx_fail <= 1'b0;
		rchk(RBM_OFF_COMMAND, 32'h22);
		apb(1'b0, RBM_OFF_INT_STATUS, 32'h0);
		`CHK(rd[RBM_IS_TX_ERR], 1'b1)
		$display("done: transmit abort");
		// Payload goes out unchanged, then the inverted check bytes
		mk(40);
		txq.delete();
		apb(1'b1, RBM_OFF_COMMAND, 32'h26);
		for (int i = 0; i < q.size() - 4; i++) begin
			tx_in_valid <= 1'b1;
			tx_in_data <= q[i];
			tx_in_last <= i == q.size() - 5;
			do @(posedge pclk); while (tx_in_ready !== 1'b1);
		end
		tx_in_valid <= 1'b0;
		tx_in_last <= 1'b0;
		repeat (10) @(posedge pclk);
		`CHK(txq.size(), q.size())
		foreach (q[i]) `CHK(txq[i], q[i])
		apb(1'b0, RBM_OFF_INT_STATUS, 32'h0);
		`CHK(rd[RBM_IS_TX_SENT], 1'b1)
		$display("done: transmit");
		test_done;
	end
endmodule : test_receive_buffer_ring_manager
bind rbm_ring rbm_ring_asserts chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pslverr(pslverr), .tx_in_valid(tx_in_valid),
	.tx_in_ready(tx_in_ready), .tx_in_last(tx_in_last),
	.tx_out_valid(tx_out_valid), .mem_we(mem_we), .mem_addr(mem_addr),
	.stopped(stopped));
